// [pkg/mem_decode_pkg.sv]
// Address map, slot population and timing constants of the memory system decoder.
package mem_decode_pkg;
  // ==========================================================================
  // Regions
  // ==========================================================================
  localparam logic [31:0] flash_base = 32'h0000_0000;
  localparam logic [31:0] flash_size = 32'h0003_0000;
  localparam logic [31:0] code_ram_base = 32'h0080_0000;
  localparam logic [31:0] data_ram_base = 32'h2000_0000;
  localparam logic [31:0] ram_size = 32'h0000_6000;
  localparam logic [31:0] periph_base = 32'h4000_0000;
  localparam logic [31:0] periph_span = 32'h0004_0000;
  localparam logic [31:0] flash_ctrl_base = 32'h4001_e000;
  localparam logic [31:0] cipher_base = 32'h4000_f000;
  // ==========================================================================
  // Organisation
  // ==========================================================================
  localparam int section_bytes = 4096;
  localparam int sections_per_slave = 2;
  localparam int ram_slaves = 3;
  localparam int ram_sections = ram_slaves * sections_per_slave;
  localparam int ram_words = 6144;
  localparam int ram_addr_w = 13;
  localparam int section_bit = 12;
  localparam int slave_lsb = 13;
  localparam int page_bytes = 4096;
  localparam int blocks_per_page = 8;
  localparam int block_lsb = 9;
  localparam int page_lsb = 12;
  localparam int slot_lsb = 12;
  localparam int slot_w = 6;
  localparam logic [5:0] shared_cipher_slot = 6'h0f;
  localparam logic [5:0] flash_ctrl_slot = 6'h1e;
  // Populated slots: 0-4, 6-25, 28-31.
  localparam logic [63:0] slot_populated = 64'h0000_0000_f3ff_ffdf;
  localparam logic [1:0] flash_wait_max = 2'h2;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait = 2'b01,
    st_err1 = 2'b10,
    st_err2 = 2'b11
  } access_state_t;
endpackage

// [pkg/ram_port_if.sv]
// Connection between the decoder and its RAM storage.
interface ram_port_if;
  logic wr;
  logic [12:0] addr;
  logic [3:0] be;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport master (output wr, output addr, output be, output wdata, input rdata);
  modport slave (input wr, input addr, input be, input wdata, output rdata);
endinterface

// [logic/ram_store.sv]
// Single physical RAM array with byte-lane writes and registered read data.
module ram_store (
  input wire logic core_clk,
  ram_port_if.slave port
);
  import mem_decode_pkg::*;
  logic [31:0] mem [ram_words];
  logic [31:0] rdata_reg;
  // ==========================================================================
  // Storage
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (port.wr) begin
      for (int b = 0; b < 4; b++) begin
        if (port.be[b]) begin
          mem[port.addr][8*b +: 8] <= port.wdata[8*b +: 8]; // [RL13]
        end
      end
    end
    rdata_reg <= mem[port.addr];
  end
  assign port.rdata = rdata_reg;
endmodule

// [logic/memory_system_address_decode.sv]
// Address decoder joining processor and DMA masters to RAM and flash, and the processor alone to peripheral slots.
// How it works
// (RL1) Code and data RAM aliases share storage.
// (RL2) Masters partition aliased RAM themselves.
// (RL3) Each RAM slave serves two 4 kB sections.
// (RL4) Sections take per-state power control inputs.
// (RL5) Flash pages 4 kB, 8 blocks, both buses.
// (RL6) Flash reads free; writes go to controller.
// (RL7) Processor flash access waits 0 to 2.
// (RL8) RAM answers with zero wait states.
// (RL9) CPU and DMA reach memory; CPU peripherals.
// (RL10) Slot 15 shared by resolver and cipher.
// (RL11) Flash controller decoded at slot 30.
// (RL12) 4 kB slots; empty slot gives error.
// (RL13) Little-endian byte lanes throughout.
module memory_system_address_decode (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cpu_sel,
  input wire logic cpu_write,
  input wire logic [31:0] cpu_addr,
  input wire logic [1:0] cpu_size,
  input wire logic [31:0] cpu_wdata,
  input wire logic [1:0] flash_wait_cfg,
  input wire logic dma_sel,
  input wire logic dma_write,
  input wire logic [31:0] dma_addr,
  input wire logic [1:0] dma_size,
  input wire logic [31:0] dma_wdata,
  input wire logic [5:0] ram_on_keep,
  input wire logic [5:0] ram_off_keep,
  input wire logic [31:0] flash_rdata,
  input wire logic [31:0] periph_rdata,
  output logic cpu_ready,
  output logic cpu_err,
  output logic [31:0] cpu_rdata,
  output logic dma_ready,
  output logic dma_err,
  output logic [31:0] dma_rdata,
  output logic flash_rd,
  output logic [31:0] flash_addr,
  output logic [2:0] flash_block,
  output logic flash_from_dma,
  output logic periph_sel,
  output logic periph_write,
  output logic [5:0] periph_slot,
  output logic [11:0] periph_offset,
  output logic [31:0] periph_wdata,
  output logic flash_ctrl_sel,
  output logic cipher_sel,
  output logic [5:0] section_on,
  output logic [5:0] section_keep_off
);
  import mem_decode_pkg::*;
  ram_port_if ram_bus ();
  ram_store u_ram (.core_clk(core_clk), .port(ram_bus.slave));

  // ==========================================================================
  // Region decode
  // ==========================================================================
  function automatic logic in_ram(input logic [31:0] a);
    return ((a >= code_ram_base) && (a < code_ram_base + ram_size)) ||
           ((a >= data_ram_base) && (a < data_ram_base + ram_size)); // [RL1]
  endfunction
  function automatic logic in_flash(input logic [31:0] a);
    return (a < flash_base + flash_size);
  endfunction
  function automatic logic in_periph(input logic [31:0] a);
    return (a >= periph_base) && (a < periph_base + periph_span);
  endfunction
  function automatic logic [3:0] lanes(input logic [1:0] a, input logic [1:0] sz);
    case (sz)
      2'h0: lanes = 4'h1 << a; // [RL13]
      2'h1: lanes = a[1] ? 4'hc : 4'h3;
      default: lanes = 4'hf;
    endcase
  endfunction

  logic cpu_ram, cpu_flash, cpu_per, dma_ram, dma_flash, dma_go;
  logic [5:0] cpu_slot;
  logic dma_gets_ram;
  always_comb begin
    // A DMA request held over its own answer is not taken a second time.
    dma_go = dma_sel && !dma_ready && !dma_err;
    cpu_ram = cpu_sel && in_ram(cpu_addr);
    cpu_flash = cpu_sel && in_flash(cpu_addr);
    cpu_per = cpu_sel && in_periph(cpu_addr); // [RL9]
    dma_ram = dma_go && in_ram(dma_addr); // [RL9]
    dma_flash = dma_go && in_flash(dma_addr);
    cpu_slot = cpu_addr[slot_lsb +: slot_w]; // [RL12]
    dma_gets_ram = dma_ram && !cpu_ram;
  end

  // ==========================================================================
  // RAM path: alias folding, section select, zero wait states
  // ==========================================================================
  logic [31:0] ram_a;
  always_comb begin
    ram_a = dma_gets_ram ? dma_addr : cpu_addr;
    // Both aliases fold to the same offset; nothing guards one alias from the other. [RL2]
    // Slave, then section within the slave, then word within the 4 kB section. [RL3]
    ram_bus.addr = {ram_a[slave_lsb +: 2], ram_a[section_bit], ram_a[2 +: 10]}; // [RL1]
    ram_bus.wr = dma_gets_ram ? dma_write : (cpu_ram && cpu_write);
    ram_bus.be = dma_gets_ram ? lanes(dma_addr[1:0], dma_size) : lanes(cpu_addr[1:0], cpu_size);
    ram_bus.wdata = dma_gets_ram ? dma_wdata : cpu_wdata;
  end

  // ==========================================================================
  // Processor access sequencing
  // ==========================================================================
  access_state_t st_reg, st_next;
  logic [1:0] wait_reg, wait_next;
  logic cpu_ready_next, cpu_err_next, flash_rd_next, cpu_rsel_next;
  logic cpu_rsel_reg;
  logic [1:0] wcfg_s1_reg, wcfg_s2_reg;
  logic bad_cpu, bad_slot, periph_go;
  always_comb begin
    bad_slot = cpu_per && !slot_populated[cpu_slot]; // [RL12]
    periph_go = cpu_per && !bad_slot && (st_reg == st_idle) && !cpu_ready; // [RL9]
    // Flash writes are not a bus path here; they belong to the flash controller. [RL6]
    bad_cpu = (cpu_flash && cpu_write) || bad_slot ||
              (cpu_sel && !cpu_ram && !cpu_flash && !cpu_per);
    st_next = st_reg;
    wait_next = wait_reg;
    cpu_ready_next = 1'b0;
    cpu_err_next = 1'b0;
    flash_rd_next = 1'b0;
    cpu_rsel_next = 1'b0;
    case (st_reg)
      st_idle: begin
        if (cpu_ready) begin
          // The answer still stands; the request held over it is the same one.
          st_next = st_idle;
        end else if (bad_cpu) begin
          st_next = st_err1;
          cpu_err_next = 1'b1;
        end else if (cpu_flash) begin
          flash_rd_next = 1'b1; // [RL6]
          if (wcfg_s2_reg == 2'h0) begin
            cpu_ready_next = 1'b1; // [RL7]
            cpu_rsel_next = 1'b1;
          end else begin
            st_next = st_wait;
            wait_next = (wcfg_s2_reg > flash_wait_max) ? flash_wait_max : wcfg_s2_reg; // [RL7]
          end
        end else if (cpu_ram || cpu_per) begin
          cpu_ready_next = 1'b1; // [RL8]
        end
      end
      st_wait: begin
        wait_next = wait_reg - 2'h1;
        if (wait_reg == 2'h1) begin
          st_next = st_idle;
          cpu_ready_next = 1'b1; // [RL7]
          cpu_rsel_next = 1'b1;
        end
      end
      st_err1: begin
        st_next = st_err2;
        cpu_err_next = 1'b1;
        cpu_ready_next = 1'b1;
      end
      st_err2: st_next = st_idle;
      default: st_next = st_idle;
    endcase
  end

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  logic dma_ready_next, dma_err_next, dma_from_ram_reg;
  always_comb begin
    dma_ready_next = dma_go && (dma_gets_ram || dma_flash) && !(dma_flash && dma_write);
    dma_err_next = dma_go && !dma_ready_next && !(dma_ram && cpu_ram);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= st_idle;
      wait_reg <= 2'h0;
      wcfg_s1_reg <= 2'h0;
      wcfg_s2_reg <= 2'h0;
      cpu_ready <= 1'b0;
      cpu_err <= 1'b0;
      cpu_rsel_reg <= 1'b0;
      dma_ready <= 1'b0;
      dma_err <= 1'b0;
      dma_from_ram_reg <= 1'b0;
      flash_rd <= 1'b0;
      flash_addr <= 32'h0000_0000;
      flash_block <= 3'h0;
      flash_from_dma <= 1'b0;
      periph_sel <= 1'b0;
      periph_write <= 1'b0;
      periph_slot <= 6'h00;
      periph_offset <= 12'h000;
      periph_wdata <= 32'h0000_0000;
      flash_ctrl_sel <= 1'b0;
      cipher_sel <= 1'b0;
      section_on <= 6'h00;
      section_keep_off <= 6'h00;
    end else begin
      st_reg <= st_next;
      wait_reg <= wait_next;
      wcfg_s1_reg <= flash_wait_cfg;
      wcfg_s2_reg <= wcfg_s1_reg;
      cpu_ready <= cpu_ready_next;
      cpu_err <= cpu_err_next;
      cpu_rsel_reg <= cpu_rsel_next;
      dma_ready <= dma_ready_next;
      dma_err <= dma_err_next;
      dma_from_ram_reg <= dma_gets_ram;
      flash_rd <= flash_rd_next || (dma_flash && !dma_write && !cpu_flash);
      flash_from_dma <= dma_flash && !cpu_flash;
      flash_addr <= cpu_flash ? cpu_addr : dma_addr; // [RL5]
      flash_block <= cpu_flash ? cpu_addr[block_lsb +: 3] : dma_addr[block_lsb +: 3]; // [RL5]
      periph_sel <= periph_go;
      periph_write <= cpu_write;
      periph_slot <= cpu_slot; // [RL12]
      periph_offset <= cpu_addr[11:0];
      periph_wdata <= cpu_wdata;
      flash_ctrl_sel <= periph_go && (cpu_slot == flash_ctrl_slot); // [RL11]
      cipher_sel <= periph_go && (cpu_slot == shared_cipher_slot); // [RL10]
      section_on <= ram_on_keep; // [RL4]
      section_keep_off <= ram_off_keep; // [RL4]
    end
  end

  // Read data muxes ride on the RAM's registered output, so RAM keeps zero waits.
  assign cpu_rdata = cpu_rsel_reg ? flash_rdata : (periph_sel ? periph_rdata : ram_bus.rdata);
  assign dma_rdata = dma_from_ram_reg ? ram_bus.rdata : flash_rdata;
endmodule

// [tb/bus_master_model.sv]
// Behavioural bus master standing for the processor or a DMA channel.
module bus_master_model #(
  parameter bit err_ends = 1'b0
) (
  input wire logic core_clk,
  input wire logic ready,
  input wire logic err,
  input wire logic [31:0] rdata,
  output logic sel,
  output logic write,
  output logic [31:0] addr,
  output logic [1:0] size,
  output logic [31:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] got;
  logic got_err;
  int cyc;
  initial {sel, write, addr, size, wdata} = '0;
  // ==========================================================================
  // Transfer
  // ==========================================================================
  // Callers keep code and data use of the shared RAM apart themselves.
  task automatic xfer(input logic w, input logic [1:0] s, input logic [31:0] a, d);
    @(negedge core_clk);
    {sel, write, size, addr, wdata} = {1'b1, w, s, a, d};
    got_err = 1'b0;
    for (cyc = 1; cyc < 20; cyc++) begin
      @(negedge core_clk);
      got_err |= err;
      if (ready === 1'b1 || (err_ends && err === 1'b1)) break;
    end
    got = rdata;
    // The request stands over the edge that samples the answer, then goes.
    @(negedge core_clk);
    // Released data is inverted so a stale value never looks valid.
    {sel, wdata} = {1'b0, ~d};
  endtask
endmodule

// [tb/mem_decode_chk.sv]
// Port-level checker for the memory system address decoder.
module mem_decode_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cpu_sel,
  input wire logic cpu_write,
  input wire logic [31:0] cpu_addr,
  input wire logic dma_sel,
  input wire logic [31:0] dma_addr,
  input wire logic [5:0] ram_on_keep,
  input wire logic [5:0] ram_off_keep,
  input wire logic cpu_ready,
  input wire logic cpu_err,
  input wire logic dma_err,
  input wire logic flash_rd,
  input wire logic [31:0] flash_addr,
  input wire logic [2:0] flash_block,
  input wire logic flash_from_dma,
  input wire logic periph_sel,
  input wire logic [5:0] periph_slot,
  input wire logic flash_ctrl_sel,
  input wire logic cipher_sel,
  input wire logic [5:0] section_on,
  input wire logic [5:0] section_keep_off
);
  import mem_decode_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_block_field: assert property (flash_rd |-> flash_block == flash_addr[11:9])
    else $error("flash block field wrong");
  a_ram_zero_wait: assert property ($rose(cpu_sel) &&
    cpu_addr - data_ram_base < ram_size |=> cpu_ready) else $error("ram not zero wait");
  a_flash_wait: assert property ($rose(flash_rd) && !flash_from_dma
    |-> ##[0:2] cpu_ready) else $error("flash wait too long");
  a_flash_write_err: assert property ($rose(cpu_sel) && cpu_write &&
    cpu_addr < flash_size |=> cpu_err ##1 cpu_err && cpu_ready) else $error("flash write ok");
  a_empty_slot: assert property ($rose(cpu_sel) &&
    cpu_addr[31:12] == 20'h40005 |=> cpu_err ##1 cpu_ready) else $error("empty slot ok");
  a_cipher_shared: assert property (cipher_sel |->
    periph_sel && periph_slot == shared_cipher_slot) else $error("cipher slot wrong");
  a_ctrl_slot: assert property (flash_ctrl_sel |->
    periph_sel && periph_slot == flash_ctrl_slot) else $error("controller slot wrong");
  a_power_copy: assert property ($past(rst_b) |-> section_on == $past(ram_on_keep) &&
    section_keep_off == $past(ram_off_keep)) else $error("power copy wrong");
  a_dma_no_periph: assert property ($rose(dma_sel) &&
    dma_addr[31:18] == 14'h1000 |=> dma_err && !periph_sel) else $error("dma reached periph");
  c_err: cover property (cpu_err && cpu_ready);
  c_cipher: cover property (cipher_sel);
  c_dma_flash: cover property (flash_rd && flash_from_dma);
endmodule
bind memory_system_address_decode mem_decode_chk u_chk (.*);

// [tb/memory_system_address_decode_bench.sv]
// Self-checking bench for the memory system address decoder.
module memory_system_address_decode_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mem_decode_pkg::*;
  logic core_clk = 0;
  logic rst_b = 0;
  logic [1:0] flash_wait_cfg = 0;
  logic [5:0] ram_on_keep = 0;
  logic [5:0] ram_off_keep = 0;
  logic cpu_sel, cpu_write, cpu_ready, cpu_err, dma_sel, dma_write, dma_ready, dma_err;
  logic flash_rd, flash_from_dma, periph_sel, periph_write, flash_ctrl_sel, cipher_sel;
  logic [1:0] cpu_size, dma_size;
  logic [2:0] flash_block;
  logic [5:0] periph_slot, section_on, section_keep_off;
  logic [11:0] periph_offset;
  logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, dma_addr, dma_wdata, dma_rdata;
  logic [31:0] flash_rdata, flash_addr, periph_rdata, periph_wdata;
  int err_count = 0;
  int samples_checked = 0;
  always #25 core_clk = ~core_clk;
  assign flash_rdata = ~flash_addr;
  assign periph_rdata = {14'h0, periph_slot, periph_offset};
  memory_system_address_decode u_dut (.*);
  bus_master_model u_cpu (.core_clk, .ready(cpu_ready), .err(cpu_err), .rdata(cpu_rdata),
    .sel(cpu_sel), .write(cpu_write), .addr(cpu_addr), .size(cpu_size), .wdata(cpu_wdata));
  bus_master_model #(.err_ends(1'b1)) u_dma (.core_clk, .ready(dma_ready), .err(dma_err),
    .rdata(dma_rdata),
    .sel(dma_sel), .write(dma_write), .addr(dma_addr), .size(dma_size), .wdata(dma_wdata));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // A wait that uses up its bound ends the run at once.
  task automatic cpu(input logic w, input logic [1:0] s, input logic [31:0] a, d);
    u_cpu.xfer(w, s, a, d);
    if (u_cpu.cyc >= 20) begin
      $display("CHECK FAILED cpu ready expected 1 seen 0");
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic dma(input logic w, input logic [31:0] a, d);
    u_dma.xfer(w, 2'h2, a, d);
    if (u_dma.cyc >= 20) begin
      $display("CHECK FAILED dma ready expected 1 seen 0");
      err_count++;
      report_and_stop();
    end
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_alias();
    cpu(1, 2'h2, data_ram_base + 32'h10, 32'h44332211);
    cpu(1, 2'h0, data_ram_base + 32'h11, 32'h0000aa00);
    cpu(0, 2'h2, code_ram_base + 32'h10, 32'h0);
    chk("alias data", 32'h4433aa11, u_cpu.got);
    chk("ram wait", 32'd1, 32'(u_cpu.cyc));
    $display("alias test done");
  endtask
  task automatic t_flash();
    for (int c = 0; c < 4; c++) begin
      flash_wait_cfg = 2'(c);
      repeat (4) @(negedge core_clk);
      cpu(0, 2'h2, 32'h1a04, 32'h0);
      chk("flash data", ~32'h1a04, u_cpu.got);
      chk("flash wait", 32'(1 + (c > 2 ? 2 : c)), 32'(u_cpu.cyc));
    end
    dma(0, 32'h2e08, 32'h0);
    chk("dma flash", ~32'h2e08, u_dma.got);
    cpu(1, 2'h2, 32'h100, 32'h0);
    chk("flash write err", 32'h1, 32'(u_cpu.got_err));
    $display("flash test done");
  endtask
  task automatic t_periph();
    logic [31:0] a[3] = '{32'h4000f004, 32'h4001e400, 32'h40005000};
    for (int i = 0; i < 3; i++) begin
      cpu(0, 2'h2, a[i], 32'h0);
      chk("slot err", 32'(i == 2), 32'(u_cpu.got_err));
      if (i < 2) chk("slot data", {14'h0, a[i][17:0]}, u_cpu.got);
    end
    cpu(1, 2'h2, 32'h4000f008, 32'hc3c3_5a5a);
    chk("periph write", 32'h1, 32'(periph_write));
    chk("periph wdata", 32'hc3c3_5a5a, periph_wdata);
    chk("periph offset", 32'h8, 32'(periph_offset));
    chk("periph slot", 32'hf, 32'(periph_slot));
    $display("peripheral test done");
  endtask
  task automatic t_dma();
    dma(1, data_ram_base + 32'h2020, 32'h5a5a0f0f);
    cpu(0, 2'h2, code_ram_base + 32'h2020, 32'h0);
    chk("dma ram", 32'h5a5a0f0f, u_cpu.got);
    dma(0, 32'h4000f000, 32'h0);
    chk("dma periph err", 32'h1, 32'(u_dma.got_err));
    $display("dma test done");
  endtask
  task automatic t_power();
    ram_on_keep = 6'h2a;
    ram_off_keep = 6'h15;
    repeat (2) @(negedge core_clk);
    chk("section on", 32'h2a, 32'(section_on));
    chk("section off", 32'h15, 32'(section_keep_off));
    $display("power test done");
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    rst_b = 1;
    t_alias();
    t_flash();
    t_periph();
    t_dma();
    t_power();
    report_and_stop();
  end
endmodule
